// ==== hdl/dfgr_pkg.sv ====
// package: constants and types for the fine granularity refresh block
package dfgr_pkg;

  // granularity field codes
  localparam logic [2:0] GRAN_FIXED_1X = 3'h0;
  localparam logic [2:0] GRAN_FIXED_2X = 3'h1;
  localparam logic [2:0] GRAN_FIXED_4X = 3'h2;
  localparam logic [2:0] GRAN_DYN_12   = 3'h5;
  localparam logic [2:0] GRAN_DYN_14   = 3'h6;
  localparam logic [2:0] GRAN_RESET    = GRAN_FIXED_1X;

  // register byte offsets on the bus
  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_CMD    = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h008;
  localparam logic [11:0] OFS_COUNT  = 12'h00C;

  // control register fields
  localparam int CTRL_GRAN_LSB = 6;
  localparam int CTRL_TCR_BIT  = 9;
  // command register fields (write only, self clearing)
  localparam int CMD_REF_BIT   = 0;
  localparam int CMD_BG0_BIT   = 1;
  localparam int CMD_SRE_BIT   = 2;
  localparam int CMD_SRX_BIT   = 3;

  // timing
  localparam int CLK_PERIOD_PS = 8000;
  localparam int TRFC1_NS      = 260;
  localparam int TRFC2_NS      = 160;
  localparam int TRFC4_NS      = 110;
  localparam int TRFC1_CYC     = (TRFC1_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TRFC2_CYC     = (TRFC2_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TRFC4_CYC     = (TRFC4_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TREFI_BASE_NS = 7800;
  localparam int TREFI_BASE_CYC = (TREFI_BASE_NS * 1000) / CLK_PERIOD_PS;
  localparam int CNT_W         = 16;

  typedef enum logic [1:0] {
    DFGR_RATE_1X = 2'b00,
    DFGR_RATE_2X = 2'b01,
    DFGR_RATE_4X = 2'b10
  } dfgr_rate_type;

  typedef enum logic [1:0] {
    DFGR_IDLE = 2'b00,
    DFGR_BUSY = 2'b01,
    DFGR_SELF = 2'b10
  } dfgr_state_type;

endpackage

// ==== hdl/dfgr_rate_decode.sv ====
// rate selection from granularity field and bg0
`timescale 1ns/10ps
module dfgr_rate_decode
  import dfgr_pkg::*;
(
  // selection inputs
  input  wire logic [2:0]    gran,
  input  wire logic          bg0,
  // decoded outputs
  output dfgr_rate_type      rate,
  output logic               dynamic,
  output logic               reserved
);

  always_comb begin
    dynamic  = 1'b0;
    reserved = 1'b0;
    rate     = DFGR_RATE_1X;
    case (gran)
      GRAN_FIXED_1X: rate = DFGR_RATE_1X;
      GRAN_FIXED_2X: rate = DFGR_RATE_2X;
      GRAN_FIXED_4X: rate = DFGR_RATE_4X;
      GRAN_DYN_12: begin
        dynamic = 1'b1;
        rate    = bg0 ? DFGR_RATE_2X : DFGR_RATE_1X;
      end
      GRAN_DYN_14: begin
        dynamic = 1'b1;
        rate    = bg0 ? DFGR_RATE_4X : DFGR_RATE_1X;
      end
      default: begin
        reserved = 1'b1;
        rate     = DFGR_RATE_1X;
      end
    endcase
  end

endmodule

// ==== hdl/dfgr_top.sv ====
// fine granularity refresh engine with apb register access
`timescale 1ns/10ps

module dfgr_top
  import dfgr_pkg::*;
(
  // clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // apb slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  input  wire logic [3:0]    pstrb,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  // refresh engine status
  output logic               refresh_busy,
  output logic               self_refresh
);

  logic [2:0]           granularity_field;
  logic                 temperature_controlled_refresh;
  dfgr_rate_type        cur_rate;
  dfgr_state_type       state;
  logic [8:0]           busy_cnt;
  logic [5:0]           frac_cnt;
  logic [1:0]           extra_needed;
  logic [CNT_W-1:0]     ref_total;
  logic                 reserved_seen;
  logic                 rate_violation;

  dfgr_rate_type        dec_rate;
  logic                 dec_dynamic;
  logic                 dec_reserved;
  logic                 cmd_bg0;

  logic                 wr_en;
  logic                 rd_en;
  logic                 hit;
  logic                 do_ref;
  logic                 do_sre;
  logic                 do_srx;
  logic                 ctrl_wr;
  logic [8:0]           next_busy;
  logic                 rate_change;

  assign cmd_bg0 = pwdata[CMD_BG0_BIT];

  dfgr_rate_decode u_decode (
    .gran     (granularity_field),
    .bg0      (cmd_bg0),
    .rate     (dec_rate),
    .dynamic  (dec_dynamic),
    .reserved (dec_reserved)
  );

  // bus decode: zero wait state, error on unmapped address
  assign hit = (paddr == OFS_CTRL) || (paddr == OFS_CMD) ||
               (paddr == OFS_STATUS) || (paddr == OFS_COUNT);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign wr_en   = psel && penable && pwrite && hit;
  assign rd_en   = psel && !penable && !pwrite;
  assign ctrl_wr = wr_en && (paddr == OFS_CTRL) && pstrb[0] && pstrb[1];

  // commands are refused while a refresh is in progress
  assign do_ref = wr_en && (paddr == OFS_CMD) && pstrb[0] && pwdata[CMD_REF_BIT] &&
                  (state == DFGR_IDLE);
  assign do_sre = wr_en && (paddr == OFS_CMD) && pstrb[0] && pwdata[CMD_SRE_BIT] &&
                  (state == DFGR_IDLE);
  assign do_srx = wr_en && (paddr == OFS_CMD) && pstrb[0] && pwdata[CMD_SRX_BIT] &&
                  (state == DFGR_SELF);

  // effective rate change ignores fixed/dynamic swap at same rate
  always_comb begin
    rate_change = 1'b0;
    if (ctrl_wr) begin
      case (pwdata[CTRL_GRAN_LSB +: 3])
        GRAN_FIXED_2X: rate_change = (cur_rate != DFGR_RATE_2X);
        GRAN_FIXED_4X: rate_change = (cur_rate != DFGR_RATE_4X);
        GRAN_FIXED_1X: rate_change = (cur_rate != DFGR_RATE_1X);
        GRAN_DYN_12:   rate_change = (cur_rate == DFGR_RATE_4X);
        GRAN_DYN_14:   rate_change = (cur_rate == DFGR_RATE_2X);
        default:       rate_change = 1'b1;
      endcase
    end
  end

  // mode register, reset to fixed 1x
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      granularity_field              <= GRAN_RESET;
      temperature_controlled_refresh <= 1'b0;
    end else if (ctrl_wr) begin
      granularity_field              <= pwdata[CTRL_GRAN_LSB +: 3];
      temperature_controlled_refresh <= pwdata[CTRL_TCR_BIT];
    end
  end

  // rate follows the issuing refresh or the mode write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_rate <= DFGR_RATE_1X;
    end else if (do_ref) begin
      cur_rate <= dec_rate;
    end else if (ctrl_wr) begin
      case (pwdata[CTRL_GRAN_LSB +: 3])
        GRAN_FIXED_2X: cur_rate <= DFGR_RATE_2X;
        GRAN_FIXED_4X: cur_rate <= DFGR_RATE_4X;
        GRAN_DYN_12, GRAN_DYN_14: cur_rate <= cur_rate;
        default:       cur_rate <= DFGR_RATE_1X;
      endcase
    end
  end

  // refresh cycle time chosen from the rate of this refresh
  always_comb begin
    case (dec_rate)
      DFGR_RATE_2X: next_busy = 9'(TRFC2_CYC);
      DFGR_RATE_4X: next_busy = 9'(TRFC4_CYC);
      default:      next_busy = 9'(TRFC1_CYC);
    endcase
  end

  // engine state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state    <= DFGR_IDLE;
      busy_cnt <= 9'h000;
    end else begin
      case (state)
        DFGR_IDLE: begin
          if (do_ref) begin
            state    <= DFGR_BUSY;
            busy_cnt <= next_busy - 9'h001;
          end else if (do_sre) begin
            state <= DFGR_SELF;
          end
        end
        DFGR_BUSY: begin
          if (busy_cnt == 9'h000) begin
            state <= DFGR_IDLE;
          end else begin
            busy_cnt <= busy_cnt - 9'h001;
          end
        end
        DFGR_SELF: begin
          if (do_srx) begin
            state <= DFGR_IDLE;
          end
        end
        default: state <= DFGR_IDLE;
      endcase
    end
  end

  // fractional-rate refresh count, cleared by rate-changing mode write, 1x refresh, exit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frac_cnt <= 6'h00;
    end else if (rate_change || do_srx) begin
      frac_cnt <= 6'h00;
    end else if (do_ref) begin
      if (dec_rate == DFGR_RATE_1X) begin
        frac_cnt <= 6'h00;
      end else begin
        frac_cnt <= frac_cnt + 6'h01;
      end
    end
  end

  // extra refreshes owed after exit, latched at entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      extra_needed <= 2'h0;
    end else if (do_sre) begin
      if (cur_rate == DFGR_RATE_2X && frac_cnt[0]) begin
        extra_needed <= 2'h1;
      end else if (cur_rate == DFGR_RATE_4X && frac_cnt[1:0] != 2'h0) begin
        extra_needed <= 2'h2;
      end else begin
        extra_needed <= 2'h0;
      end
    end else if (do_ref && extra_needed != 2'h0 && dec_rate == DFGR_RATE_1X) begin
      extra_needed <= 2'h0;
    end
  end

  // sticky diagnostics: reserved code, rate not permitted, tcr misuse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reserved_seen  <= 1'b0;
      rate_violation <= 1'b0;
    end else begin
      if (do_ref && dec_reserved) begin
        reserved_seen <= 1'b1;
      end else if (wr_en && paddr == OFS_STATUS && pwdata[0]) begin
        reserved_seen <= 1'b0;
      end
      if ((do_ref && !dec_dynamic && dec_rate != cur_rate && granularity_field[2]) ||
          (temperature_controlled_refresh && granularity_field != GRAN_FIXED_1X)) begin
        rate_violation <= 1'b1;
      end else if (wr_en && paddr == OFS_STATUS && pwdata[1]) begin
        rate_violation <= 1'b0;
      end
    end
  end

  // total refresh count for software accounting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_total <= '0;
    end else if (do_ref) begin
      ref_total <= ref_total + CNT_W'(1);
    end
  end

  // read data registered during setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_en) begin
      case (paddr)
        OFS_CTRL:   prdata <= {22'h000000, temperature_controlled_refresh,
                               granularity_field, 6'h00};
        OFS_STATUS: prdata <= {16'h0000, 2'h0, frac_cnt, extra_needed, cur_rate,
                               state, reserved_seen, rate_violation};
        OFS_COUNT:  prdata <= {{(32 - CNT_W){1'b0}}, ref_total};
        default:    prdata <= 32'h00000000;
      endcase
    end
  end

  assign refresh_busy = (state == DFGR_BUSY);
  assign self_refresh = (state == DFGR_SELF);

  // assertions
  // busy drops one cycle after the loaded count has run out
  localparam int TAIL1_CYC = TRFC1_CYC - 7;
  localparam int TAIL4_CYC = TRFC4_CYC;

  sequence s_ref_1x;
    do_ref && dec_rate == DFGR_RATE_1X;
  endsequence

  a_busy_1x_time: assert property (@(posedge pclk) disable iff (!presetn)
    s_ref_1x |=> refresh_busy [*8] ##TAIL1_CYC !refresh_busy)
    else $error("1x refresh cycle time wrong");

  a_busy_4x_time: assert property (@(posedge pclk) disable iff (!presetn)
    (do_ref && dec_rate == DFGR_RATE_4X) |=> refresh_busy ##TAIL4_CYC !refresh_busy)
    else $error("4x refresh cycle time wrong");

  a_dyn_bg0_rate: assert property (@(posedge pclk) disable iff (!presetn)
    (do_ref && granularity_field == GRAN_DYN_12) |=>
      cur_rate == ($past(cmd_bg0) ? DFGR_RATE_2X : DFGR_RATE_1X))
    else $error("dynamic rate not taken from bg0");

  a_reset_fixed: assert property (@(posedge pclk)
    $rose(presetn) |-> granularity_field == GRAN_FIXED_1X && cur_rate == DFGR_RATE_1X)
    else $error("not fixed 1x after reset");

  a_sre_any_cnt: assert property (@(posedge pclk) disable iff (!presetn)
    do_sre |=> self_refresh)
    else $error("self refresh entry refused");

  a_extra_2x: assert property (@(posedge pclk) disable iff (!presetn)
    (do_sre && cur_rate == DFGR_RATE_2X && frac_cnt[0]) |=> extra_needed == 2'h1)
    else $error("owed refresh after odd 2x count not flagged");

  a_frac_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (do_ref && dec_rate == DFGR_RATE_1X && !rate_change) |=> frac_cnt == 6'h00)
    else $error("fractional count not cleared on 1x");

  a_same_rate: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_wr && pwdata[CTRL_GRAN_LSB +: 3] == GRAN_FIXED_2X && cur_rate == DFGR_RATE_2X
     && !do_ref) |=> $stable(frac_cnt))
    else $error("same-rate swap treated as change");

endmodule

// ==== tb/dfgr_apb_ctrl.sv ====
// apb controller model issuing mode writes and refresh commands
`timescale 1ns/10ps
module dfgr_apb_ctrl
  import dfgr_pkg::*;
(
  // clock
  input  wire logic        pclk,
  // apb master side
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  output logic [3:0]       pstrb,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  logic [31:0] rd_data;
  logic        rd_err;

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
  end

  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // only the bench timeout ends a wait for the answer
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // stale data must not look valid once released
    pwdata <= ~d;
  endtask

  // mode write keeps temperature refresh off
  task automatic set_gran(input logic [2:0] g);
    xfer(1'b1, OFS_CTRL, 32'(g) << CTRL_GRAN_LSB);
  endtask

  task automatic cmd(input int bit_pos, input logic bg0);
    xfer(1'b1, OFS_CMD, (32'h1 << bit_pos) | (32'(bg0) << CMD_BG0_BIT));
  endtask
endmodule

// ==== tb/dram_fine_granularity_refresh_tb_top.sv ====
// self-checking bench for the fine granularity refresh block
`timescale 1ns/10ps
module dram_fine_granularity_refresh_tb_top
  import dfgr_pkg::*;
;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, refresh_busy, self_refresh;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  int          fail_count = 0;
  int          compares = 0;
  int          cycles = 0;
  int          exp_cnt = 0;

  always #4 pclk = ~pclk;

  dfgr_apb_ctrl m (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  dfgr_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .refresh_busy(refresh_busy),
    .self_refresh(self_refresh));

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      end_of_test();
    end
  end

  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic rd(input logic [11:0] a);
    m.xfer(1'b0, a, 32'h0);
  endtask

  // one refresh, then time the busy window
  task automatic ref_wait(input logic bg0, input int cyc);
    int n;
    n = 0;
    // back to back, inside the coolest-band interval, so none postponed
    m.cmd(CMD_REF_BIT, bg0);
    exp_cnt++;
    @(negedge pclk);
    while (refresh_busy === 1'b1 && n < 100) begin
      n++;
      @(negedge pclk);
    end
    chk("busy", n, cyc);
  endtask

  task automatic t_reset();
    rd(OFS_CTRL);
    chk("gran", (m.rd_data >> CTRL_GRAN_LSB) & 32'h7, 32'(GRAN_RESET));
    rd(OFS_STATUS);
    chk("status", m.rd_data & 32'h3C, 32'h0);
  endtask

  task automatic t_mode(input logic [2:0] g, input logic bg0, input int k,
                        input logic [1:0] rate, input int cyc);
    m.set_gran(g);
    rd(OFS_CTRL);
    chk("gran", (m.rd_data >> CTRL_GRAN_LSB) & 32'h7, 32'(g));
    for (int i = 0; i < k; i++) begin
      ref_wait(bg0, cyc);
    end
    rd(OFS_STATUS);
    chk("rate", (m.rd_data >> 4) & 32'h3, 32'(rate));
    rd(OFS_COUNT);
    chk("count", m.rd_data & 32'hFFFF, 32'(exp_cnt));
  endtask

  task automatic t_refuse();
    m.cmd(CMD_REF_BIT, 1'b0);
    m.cmd(CMD_REF_BIT, 1'b0);
    exp_cnt++;
    repeat (TRFC1_CYC + 2) @(posedge pclk);
    rd(OFS_COUNT);
    chk("busy refused", m.rd_data & 32'hFFFF, 32'(exp_cnt));
    chk("mapped err", 32'(m.rd_err), 32'h0);
    rd(12'h010);
    chk("unmapped err", 32'(m.rd_err), 32'h1);
  endtask

  // a refresh under a reserved code raises the sticky flag
  task automatic t_reserved(input logic [2:0] g);
    m.set_gran(g);
    ref_wait(1'b0, TRFC1_CYC);
    rd(OFS_STATUS);
    chk("reserved flag", m.rd_data & 32'h3, 32'h2);
    m.xfer(1'b1, OFS_STATUS, 32'h3);
    rd(OFS_STATUS);
    chk("reserved clr", m.rd_data & 32'h3, 32'h0);
    m.set_gran(GRAN_FIXED_1X);
  endtask

  // temperature refresh with a non-normal field is flagged
  task automatic t_tcr();
    m.xfer(1'b1, OFS_CTRL, (32'h1 << CTRL_TCR_BIT) | (32'(GRAN_FIXED_2X) << CTRL_GRAN_LSB));
    rd(OFS_STATUS);
    chk("tcr misuse", m.rd_data & 32'h3, 32'h1);
    m.set_gran(GRAN_FIXED_1X);
    m.xfer(1'b1, OFS_STATUS, 32'h3);
    rd(OFS_STATUS);
    chk("tcr clr", m.rd_data & 32'h3, 32'h0);
  endtask

  // fixed/dynamic swap at one rate keeps the fractional count
  task automatic t_swap();
    m.set_gran(GRAN_FIXED_2X);
    ref_wait(1'b0, TRFC2_CYC);
    m.set_gran(GRAN_DYN_12);
    rd(OFS_STATUS);
    chk("swap to dyn", (m.rd_data >> 8) & 32'h3F, 32'h1);
    m.set_gran(GRAN_FIXED_2X);
    rd(OFS_STATUS);
    chk("swap to fixed", (m.rd_data >> 8) & 32'h3F, 32'h1);
    ref_wait(1'b0, TRFC2_CYC);
    m.set_gran(GRAN_FIXED_1X);
    rd(OFS_STATUS);
    chk("rate change", m.rd_data & 32'h3F30, 32'h0);
  endtask

  // partial group before entry leaves extra refreshes owed
  task automatic t_self(input logic [2:0] g, input int cyc, input logic [1:0] owed);
    m.set_gran(g);
    ref_wait(1'b1, cyc);
    rd(OFS_STATUS);
    chk("fraction", (m.rd_data >> 8) & 32'h3F, 32'h1);
    m.cmd(CMD_SRE_BIT, 1'b0);
    @(negedge pclk);
    chk("in self", 32'(self_refresh), 32'h1);
    m.cmd(CMD_SRX_BIT, 1'b0);
    @(negedge pclk);
    chk("out self", 32'(self_refresh), 32'h0);
    rd(OFS_STATUS);
    chk("owed", (m.rd_data >> 6) & 32'h3, 32'(owed));
    chk("fraction clr", (m.rd_data >> 8) & 32'h3F, 32'h0);
    ref_wait(1'b0, TRFC1_CYC);
    rd(OFS_STATUS);
    chk("owed clr", (m.rd_data >> 6) & 32'h3, 32'h0);
    m.set_gran(GRAN_FIXED_1X);
  endtask

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_mode(GRAN_FIXED_1X, 1'b0, 1, 2'd0, TRFC1_CYC);
    t_mode(GRAN_FIXED_2X, 1'b0, 2, 2'd1, TRFC2_CYC);
    t_mode(GRAN_DYN_12, 1'b1, 2, 2'd1, TRFC2_CYC);
    t_mode(GRAN_DYN_12, 1'b0, 1, 2'd0, TRFC1_CYC);
    t_mode(GRAN_FIXED_4X, 1'b0, 4, 2'd2, TRFC4_CYC);
    t_mode(GRAN_DYN_14, 1'b1, 4, 2'd2, TRFC4_CYC);
    t_mode(GRAN_DYN_14, 1'b0, 1, 2'd0, TRFC1_CYC);
    t_mode(GRAN_FIXED_1X, 1'b0, 1, 2'd0, TRFC1_CYC);
    t_refuse();
    t_reserved(3'h3);
    t_reserved(3'h4);
    t_reserved(3'h7);
    t_tcr();
    t_self(GRAN_DYN_12, TRFC2_CYC, 2'd1);
    t_self(GRAN_DYN_14, TRFC4_CYC, 2'd2);
    t_swap();
    end_of_test();
  end
endmodule
